//--- logic/asic_core.sv
// Angle sensor digital core with I2C slave memory map and PWM output.
`timescale 1ns/1ps
`include "asic_consts.svh"
module asic_core #(
	parameter logic [15:0] LOT_YEAR = 16'h3030,
	parameter logic [15:0] LOT_WEEK = 16'h3030,
	parameter logic [15:0] LOT_INTERNAL = 16'h3030
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Converter front end
	input asic_pkg::asic_adc_t adc_i,
	output logic sample_strobe_o,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address strap
	input wire logic address_override_pin_i,
	// PWM output
	output logic pwm_o
);
	import asic_pkg::*;

	asic_state_t q;
	asic_state_t s;
	logic tick;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] my_addr;
	logic [15:0] rd_mux;
	logic [15:0] wr_val;
	logic [11:0] sensed;
	logic [11:0] cal;
	logic [19:0] acc;
	logic [19:0] quo;
	logic [11:0] filt;
	logic [11:0] delta;
	logic [21:0] pwm_lhs;
	logic [21:0] pwm_rhs;

	function automatic logic [11:0] wrap_sub(input logic [11:0] a, input logic [12:0] b);
		logic [13:0] d;
		d = {2'h0, a} + `ASIC_FULL_TURN - {1'h0, b};
		if (d >= `ASIC_FULL_TURN) begin
			d = d - `ASIC_FULL_TURN;
		end
		wrap_sub = d[11:0];
	endfunction : wrap_sub

	assign tick = (q.smp_cnt == 11'(`ASIC_SAMPLE_CYC - 1));
	assign sample_strobe_o = tick;
	// Open drain: the pin is only ever pulled low.
	assign sda_o = 1'h0;
	assign sda_oe_o = q.sda_oe;
	assign pwm_o = q.pwm;
	assign my_addr = q.use_ovr ? `ASIC_OVR_ADDR : q.par.addr;
	assign wr_val = {q.wr_msb, q.shift};

	// Read mux; narrow values are zero extended.
	always_comb begin
		case (q.loc)
			`ASIC_LOC_ANGLE: rd_mux = {4'h0, q.angle};
			`ASIC_LOC_SIN: rd_mux = {4'h0, q.sin_v};
			`ASIC_LOC_COS: rd_mux = {4'h0, q.cos_v};
			`ASIC_LOC_DIR: rd_mux = {15'h0000, q.dir};
			`ASIC_LOC_SENSE: rd_mux = {15'h0000, q.par.sense};
			`ASIC_LOC_OFFS: rd_mux = {2'h0, q.par.offs};
			`ASIC_LOC_WEIGHT: rd_mux = {8'h00, q.par.weight};
			`ASIC_LOC_HYST: rd_mux = {8'h00, q.par.hyst};
			`ASIC_LOC_ADDR: rd_mux = {8'h00, q.par.addr};
			`ASIC_LOC_LOTY: rd_mux = LOT_YEAR;
			`ASIC_LOC_LOTW: rd_mux = LOT_WEEK;
			`ASIC_LOC_LOTI: rd_mux = LOT_INTERNAL;
			default: rd_mux = 16'h0000;
		endcase
	end

	// Angle path: sense, offset, filter, hysteresis.
	always_comb begin
		sensed = q.par.sense ? wrap_sub(12'h000, {1'h0, adc_i.angle}) : adc_i.angle;
		cal = wrap_sub(sensed, q.par.offs[12:0]);
		acc = 20'(cal) + 20'(q.par.weight - 8'h01) * 20'(q.angle);
		quo = acc / 20'(q.par.weight);
		// Averaging across the 3600 wrap blends both ends; keep heavy filtering away from zero.
		filt = (q.par.weight == 8'h01) ? cal : quo[11:0];
		delta = wrap_sub(filt, {1'h0, q.ref_ang});
		pwm_lhs = 22'(q.pwm_cnt) * 22'(`ASIC_FULL_TURN);
		pwm_rhs = 22'(q.angle) * 22'(`ASIC_PWM_CYC);
	end

	always_comb begin
		s = q;
		// Pin synchronisers: a level counts once stages two and three agree.
		s.sy.scl_sync = {q.sy.scl_sync[1:0], scl_i};
		s.sy.sda_sync = {q.sy.sda_sync[1:0], sda_i};
		s.sy.pin_sync = {q.sy.pin_sync[1:0], address_override_pin_i};
		if (q.sy.scl_sync[1] == q.sy.scl_sync[2]) begin
			s.sy.scl = q.sy.scl_sync[2];
		end
		if (q.sy.sda_sync[1] == q.sy.sda_sync[2]) begin
			s.sy.sda = q.sy.sda_sync[2];
		end
		scl_rise = s.sy.scl & ~q.sy.scl;
		scl_fall = ~s.sy.scl & q.sy.scl;
		start_c = q.sy.scl & s.sy.scl & q.sy.sda & ~s.sy.sda;
		stop_c = q.sy.scl & s.sy.scl & ~q.sy.sda & s.sy.sda;

		// Strap is caught once after reset release, never again.
		if (!q.strap_done) begin
			if (q.strap_cnt != `ASIC_STRAP_WAIT) begin
				s.strap_cnt = q.strap_cnt + 2'h1;
			end else if (q.sy.pin_sync[1] == q.sy.pin_sync[2]) begin
				s.use_ovr = ~q.sy.pin_sync[2];
				s.strap_done = 1'h1;
			end
		end

		// Sample timing, raw vectors and angle.
		s.smp_cnt = tick ? 11'h000 : q.smp_cnt + 11'h001;
		if (tick) begin
			s.sin_v = adc_i.sine;
			s.cos_v = adc_i.cosine;
			s.angle = filt;
			if ((delta < 12'(`ASIC_HALF_TURN)) && (delta > {4'h0, q.par.hyst})) begin
				s.dir = 1'h1;
				s.ref_ang = filt;
			end else if ((delta >= 12'(`ASIC_HALF_TURN)) &&
					((12'(`ASIC_FULL_TURN) - delta) > {4'h0, q.par.hyst})) begin
				s.dir = 1'h0;
				s.ref_ang = filt;
			end
		end

		// PWM carrier.
		s.pwm_cnt = (q.pwm_cnt == 10'(`ASIC_PWM_CYC - 1)) ? 10'h000 : q.pwm_cnt + 10'h001;
		s.pwm = (pwm_lhs < pwm_rhs);

		// I2C slave. Bits are taken from the filtered level that settles on the clock rise,
		// because the device's own release after an acknowledge reaches the filter with it.
		case (q.st)
			I2C_IDLE: begin
				s.sda_oe = 1'h0;
			end
			I2C_ADDR: begin
				if (scl_rise) begin
					s.shift = {q.shift[6:0], s.sy.sda};
					s.bit_cnt = q.bit_cnt + 4'h1;
				end else if (scl_fall && (q.bit_cnt == 4'h8)) begin
					if (q.shift[7:1] == my_addr[7:1]) begin
						s.rw = q.shift[0];
						s.sda_oe = 1'h1;
						s.st = I2C_AACK;
					end else begin
						s.st = I2C_IDLE;
					end
				end
			end
			I2C_AACK: begin
				if (scl_fall) begin
					s.bit_cnt = 4'h0;
					if (q.rw) begin
						s.rd_word = rd_mux;
						s.shift = rd_mux[15:8];
						s.sda_oe = ~rd_mux[15];
						s.rd_idx = 1'h0;
						s.st = I2C_RD;
					end else begin
						s.sda_oe = 1'h0;
						s.st = I2C_WR;
					end
				end
			end
			I2C_WR: begin
				if (scl_rise) begin
					s.shift = {q.shift[6:0], s.sy.sda};
					s.bit_cnt = q.bit_cnt + 4'h1;
				end else if (scl_fall && (q.bit_cnt == 4'h8)) begin
					s.sda_oe = 1'h1;
					s.st = I2C_WACK;
					case (q.wr_idx)
						2'h0: begin
							s.loc = q.shift;
							s.wr_idx = 2'h1;
						end
						2'h1: begin
							s.wr_msb = q.shift;
							s.wr_idx = 2'h2;
						end
						2'h2: begin
							s.wr_idx = 2'h3;
							// Parameter store: out-of-range values are dropped.
							case (q.loc)
								`ASIC_LOC_SENSE: begin
									if (wr_val <= 16'h0001) s.par.sense = wr_val[0];
								end
								`ASIC_LOC_OFFS: begin
									if (wr_val <= 16'(`ASIC_FULL_TURN)) s.par.offs = wr_val[13:0];
								end
								`ASIC_LOC_WEIGHT: begin
									if ((wr_val != 16'h0000) && (wr_val <= 16'h00ff)) begin
										s.par.weight = wr_val[7:0];
									end
								end
								`ASIC_LOC_HYST: begin
									if (wr_val <= 16'h00ff) s.par.hyst = wr_val[7:0];
								end
								`ASIC_LOC_ADDR: begin
									if ((wr_val >= 16'(`ASIC_ADDR_MIN)) && (wr_val <= 16'(`ASIC_ADDR_MAX))) begin
										s.par.addr = wr_val[7:0];
									end
								end
								default: begin
								end
							endcase
						end
						default: begin
						end
					endcase
				end
			end
			I2C_WACK: begin
				if (scl_fall) begin
					s.sda_oe = 1'h0;
					s.bit_cnt = 4'h0;
					s.st = I2C_WR;
				end
			end
			I2C_RD: begin
				if (scl_fall) begin
					if (q.bit_cnt == 4'h7) begin
						s.sda_oe = 1'h0;
						s.st = I2C_RACK;
					end else begin
						s.bit_cnt = q.bit_cnt + 4'h1;
						s.shift = {q.shift[6:0], 1'h0};
						s.sda_oe = ~q.shift[6];
					end
				end
			end
			I2C_RACK: begin
				if (scl_rise) begin
					s.nack = s.sy.sda;
				end else if (scl_fall) begin
					if (q.nack) begin
						s.st = I2C_IDLE;
					end else begin
						// Bytes past the pair read as 8'h80: the first bit is released, the other seven are driven low.
						s.shift = q.rd_idx ? 8'h00 : q.rd_word[7:0];
						s.sda_oe = q.rd_idx ? 1'h0 : ~q.rd_word[7];
						s.rd_idx = 1'h1;
						s.bit_cnt = 4'h0;
						s.st = I2C_RD;
					end
				end
			end
			default: begin
				s.sda_oe = 1'h0;
				s.st = I2C_IDLE;
			end
		endcase
		if (start_c) begin
			s.st = I2C_ADDR;
			s.bit_cnt = 4'h0;
			s.sda_oe = 1'h0;
			s.wr_idx = 2'h0;
		end else if (stop_c) begin
			s.st = I2C_IDLE;
			s.sda_oe = 1'h0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.sy.scl_sync <= 3'h7;
			q.sy.sda_sync <= 3'h7;
			q.sy.pin_sync <= 3'h7;
			q.sy.scl <= 1'h1;
			q.sy.sda <= 1'h1;
			q.par.sense <= `ASIC_RST_SENSE;
			q.par.offs <= `ASIC_RST_OFFS;
			q.par.weight <= `ASIC_RST_WEIGHT;
			q.par.hyst <= `ASIC_RST_HYST;
			q.par.addr <= `ASIC_RST_ADDR;
			q.loc <= `ASIC_LOC_ANGLE;
			q.st <= I2C_IDLE;
		end else begin
			q <= s;
		end
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	a_sample_period: assert property (tick |=> (q.smp_cnt == 11'h000) ##1 !tick)
		else $error("sample period broken");
	a_angle_range: assert property ({2'h0, q.angle} < `ASIC_FULL_TURN)
		else $error("angle out of range");
	a_weight_bypass: assert property ((tick && q.par.weight == 8'h01) |=> q.angle == $past(cal))
		else $error("unit weight not bypassed");
	a_weight_legal: assert property (q.par.weight != 8'h00)
		else $error("zero weight stored");
	a_offs_legal: assert property (q.par.offs <= `ASIC_FULL_TURN)
		else $error("offset out of range");
	a_loc_persist: assert property ($changed(q.loc) |-> $past(q.st == I2C_WR && q.wr_idx == 2'h0))
		else $error("location changed outside a write");
	a_sda_release: assert property (sda_oe_o |-> (q.st inside {I2C_AACK, I2C_WACK, I2C_RD}))
		else $error("data line driven out of turn");
	a_write_ack: assert property ((q.st == I2C_WACK) |-> sda_oe_o)
		else $error("written byte not acknowledged");
	a_dir_hold: assert property ($changed(q.dir) |-> $past(tick))
		else $error("direction changed off sample");
	a_strap_once: assert property ($changed(q.use_ovr) |-> $past(!q.strap_done))
		else $error("strap resampled");
	a_pwm_duty: assert property ((q.pwm_cnt == 10'h000 && q.angle != 12'h000) |=> pwm_o)
		else $error("pwm low at start of period");
	c_read_done: cover property (q.st == I2C_RACK && scl_fall && q.nack);
	c_param_write: cover property (q.st == I2C_WR && scl_fall && q.wr_idx == 2'h2);
	c_dir_flip: cover property ($changed(q.dir));
	c_override: cover property (q.strap_done && q.use_ovr);
endmodule : asic_core

//--- logic/asic_consts.svh
// Memory locations, reset values and timing counts of the angle sensor core.
`ifndef ASIC_CONSTS_SVH
`define ASIC_CONSTS_SVH
`define ASIC_LOC_ANGLE 8'h00
`define ASIC_LOC_SIN 8'h01
`define ASIC_LOC_COS 8'h02
`define ASIC_LOC_DIR 8'h03
`define ASIC_LOC_SENSE 8'h40
`define ASIC_LOC_OFFS 8'h41
`define ASIC_LOC_WEIGHT 8'h42
`define ASIC_LOC_HYST 8'h43
`define ASIC_LOC_ADDR 8'h44
`define ASIC_LOC_LOTY 8'h80
`define ASIC_LOC_LOTW 8'h81
`define ASIC_LOC_LOTI 8'h82
`define ASIC_RST_SENSE 1'h0
`define ASIC_RST_OFFS 14'h0000
`define ASIC_RST_WEIGHT 8'h01
`define ASIC_RST_HYST 8'h19
`define ASIC_RST_ADDR 8'h48
`define ASIC_OVR_ADDR 8'h10
`define ASIC_ADDR_MIN 8'h10
`define ASIC_ADDR_MAX 8'hee
`define ASIC_FULL_TURN 14'he10
`define ASIC_HALF_TURN 14'h0708
`define ASIC_CLK_HZ 20000000
`define ASIC_SAMPLE_HZ 12500
`define ASIC_PWM_HZ 24000
`define ASIC_SAMPLE_CYC (`ASIC_CLK_HZ / `ASIC_SAMPLE_HZ)
`define ASIC_PWM_CYC (`ASIC_CLK_HZ / `ASIC_PWM_HZ)
`define ASIC_NV_WRITE_MS 15
`define ASIC_STRAP_WAIT 2'h3
`endif

//--- logic/asic_pkg.sv
// Types shared by the angle sensor core.
package asic_pkg;
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_AACK = 7'h04,
		I2C_WR = 7'h08,
		I2C_WACK = 7'h10,
		I2C_RD = 7'h20,
		I2C_RACK = 7'h40
	} asic_i2c_st_t;
	typedef struct packed {
		logic [11:0] angle;
		logic [11:0] sine;
		logic [11:0] cosine;
	} asic_adc_t;
	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic [2:0] pin_sync;
		logic scl;
		logic sda;
	} asic_sync_t;
	typedef struct packed {
		logic sense;
		logic [13:0] offs;
		logic [7:0] weight;
		logic [7:0] hyst;
		logic [7:0] addr;
	} asic_param_t;
	typedef struct packed {
		asic_sync_t sy;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic use_ovr;
		asic_param_t par;
		asic_i2c_st_t st;
		logic [7:0] loc;
		logic [1:0] wr_idx;
		logic [7:0] wr_msb;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic rw;
		logic nack;
		logic rd_idx;
		logic [15:0] rd_word;
		logic sda_oe;
		logic [10:0] smp_cnt;
		logic [11:0] angle;
		logic [11:0] sin_v;
		logic [11:0] cos_v;
		logic [11:0] ref_ang;
		logic dir;
		logic [9:0] pwm_cnt;
		logic pwm;
	} asic_state_t;
endpackage : asic_pkg

//--- test/asic_master.sv
// I2C bus master model that reads and writes the sensor memory.
`timescale 1ns/1ps
module asic_master (
	// Clock that paces the bus
	input wire logic clk_sys_i,
	// Device pull on the data line
	input wire logic sda_oe_i,
	// Bus lines
	output logic scl_o,
	output logic sda_o
);
	logic pull_low;
	// The data line has a pull-up, so a line that nobody pulls reads high.
	assign sda_o = !(pull_low || sda_oe_i);
	initial begin
		scl_o = 1'b1;
		pull_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	// A bit takes 8 clocks; data moves mid-low so the device sees it settle before the rise.
	task automatic bit_x(input logic b, output logic r);
		pull_low <= !b;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		r = sda_o;
		scl_o <= 1'b0;
		tick(2);
	endtask : bit_x
	task automatic byte_x(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ack_in, ack);
	endtask : byte_x
	task automatic start();
		tick(2);
		pull_low <= 1'b1;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask : start
	task automatic stop();
		pull_low <= 1'b1;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		pull_low <= 1'b0;
		tick(8);
	endtask : stop
	// The core stores at once, so the long settle wait after writes is left out.
	task automatic write_loc(input logic [7:0] dev, input logic [7:0] loc, input logic [15:0] val,
			input logic with_val, output logic ack);
		logic [7:0] rx;
		logic a1;
		start();
		byte_x({dev[7:1], 1'b0}, 1'b1, rx, ack);
		byte_x(loc, 1'b1, rx, a1);
		if (with_val) begin
			byte_x(val[15:8], 1'b1, rx, a1);
			byte_x(val[7:0], 1'b1, rx, a1);
		end
		stop();
	endtask : write_loc
	task automatic read_word(input logic [7:0] dev, output logic [15:0] val, output logic ack);
		logic [7:0] rx;
		logic a1;
		start();
		byte_x({dev[7:1], 1'b1}, 1'b1, rx, ack);
		byte_x(8'hff, 1'b0, val[15:8], a1);
		byte_x(8'hff, 1'b1, val[7:0], a1);
		stop();
	endtask : read_word
endmodule : asic_master

//--- test/angle_sensor_i2c_core_test.sv
// Self-checking bench for the angle sensor core.
`timescale 1ns/1ps
module angle_sensor_i2c_core_test;
	import asic_pkg::*;
	typedef struct packed {
		logic [7:0] loc;
		logic wr;
		logic [15:0] val;
		logic [15:0] exp;
	} asic_row_t;
	logic clk_sys_i, rst_n_i, pin, strobe, sda_oe, sda_dev, scl, sda, pwm, ack;
	asic_adc_t adc;
	logic [15:0] rd;
	int mismatches = 0;
	int n_checks = 0;
	int hi;
	asic_row_t rows [24] = '{
		'{8'h40, 1'h0, 16'h0, 16'h0000}, '{8'h41, 1'h0, 16'h0, 16'h0000},
		'{8'h42, 1'h0, 16'h0, 16'h0001}, '{8'h43, 1'h0, 16'h0, 16'h0019},
		'{8'h44, 1'h0, 16'h0, 16'h0048}, '{8'h01, 1'h0, 16'h0, 16'h0800},
		'{8'h02, 1'h0, 16'h0, 16'h0400}, '{8'h03, 1'h0, 16'h0, 16'h0001},
		'{8'h80, 1'h0, 16'h0, 16'h3030}, '{8'h81, 1'h0, 16'h0, 16'h3030},
		'{8'h82, 1'h0, 16'h0, 16'h3030}, '{8'h01, 1'h1, 16'h1234, 16'h0800},
		'{8'h80, 1'h1, 16'h0, 16'h3030}, '{8'h41, 1'h1, 16'h0064, 16'h0064},
		'{8'h00, 1'h0, 16'h0, 16'h0384}, '{8'h03, 1'h0, 16'h0, 16'h0000},
		'{8'h40, 1'h1, 16'h0001, 16'h0001},
		'{8'h00, 1'h0, 16'h0, 16'h09c4}, '{8'h41, 1'h1, 16'h0e11, 16'h0064},
		'{8'h40, 1'h1, 16'h0, 16'h0000}, '{8'h41, 1'h1, 16'h0, 16'h0000},
		'{8'h43, 1'h1, 16'h00ff, 16'h00ff}, '{8'h44, 1'h1, 16'h0008, 16'h0048},
		'{8'h42, 1'h1, 16'h0004, 16'h0004}
	};
	asic_core dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .adc_i(adc), .sample_strobe_o(strobe),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_dev), .sda_oe_o(sda_oe),
		.address_override_pin_i(pin), .pwm_o(pwm)
	);
	// The line is pulled low only where the device enables a low output level.
	asic_master m (.clk_sys_i(clk_sys_i), .sda_oe_i(sda_oe && !sda_dev), .scl_o(scl), .sda_o(sda));
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check16
	task automatic check1(input logic got, input logic exp, input string what);
		check16({15'h0, got}, {15'h0, exp}, what);
	endtask : check1
	// Strobe is combinational, so it is looked at on the falling edge where it has settled.
	task automatic wait_strobe();
		int k;
		k = 0;
		@(negedge clk_sys_i);
		while (strobe !== 1'b1 && k < 2000) begin
			@(negedge clk_sys_i);
			k++;
		end
		if (k == 2000) begin
			mismatches++;
			$display("FAIL %0t no sample strobe", $time);
			results();
		end
		repeat (2) @(posedge clk_sys_i);
	endtask : wait_strobe
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		rst_n_i = 1'b0;
		pin = 1'b1;
		adc = '{angle: 12'h3e8, sine: 12'h800, cosine: 12'h400};
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wait_strobe();
		m.read_word(8'h48, rd, ack);
		check1(ack, 1'b0, "default address");
		check16(rd, 16'h03e8, "angle without location write");
		foreach (rows[i]) begin
			m.write_loc(8'h48, rows[i].loc, rows[i].val, rows[i].wr, ack);
			check1(ack, 1'b0, "write address");
			if (rows[i].wr) begin
				wait_strobe();
			end
			m.read_word(8'h48, rd, ack);
			check16(rd, rows[i].exp, "memory row");
		end
		m.write_loc(8'h48, 8'h00, 16'h0, 1'b0, ack);
		wait_strobe();
		adc.angle <= 12'h7d0;
		wait_strobe();
		m.read_word(8'h48, rd, ack);
		check16(rd, 16'h04e2, "filter first step");
		wait_strobe();
		m.read_word(8'h48, rd, ack);
		check16(rd, 16'h059d, "filter second step");
		m.read_word(8'h50, rd, ack);
		check1(ack, 1'b1, "foreign address");
		rst_n_i <= 1'b0;
		pin <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wait_strobe();
		m.read_word(8'h10, rd, ack);
		check1(ack, 1'b0, "strap address");
		check16(rd, 16'h07d0, "angle at strap address");
		m.read_word(8'h48, rd, ack);
		check1(ack, 1'b1, "stored address under strap");
		hi = 0;
		repeat (833) begin
			@(negedge clk_sys_i);
			hi += pwm;
		end
		check16(16'(hi), 16'h01cf, "pwm high clocks");
		@(posedge clk_sys_i);
		adc.angle <= 12'h7e4;
		wait_strobe();
		m.write_loc(8'h10, 8'h03, 16'h0, 1'b0, ack);
		check1(ack, 1'b0, "location write under strap");
		m.read_word(8'h10, rd, ack);
		check16(rd, 16'h0000, "direction inside hysteresis");
		adc.angle <= 12'h7fe;
		wait_strobe();
		m.read_word(8'h10, rd, ack);
		check16(rd, 16'h0001, "direction past hysteresis");
		results();
	end
endmodule : angle_sensor_i2c_core_test
